// ==== verilog/ipl_prio_regs.sv ====
// Contract
// - PWM priority field at bits 6:4, read/write
// - CAN event priority field at bits 2:0
// - Code 7 is highest, codes ascend
// - Code 1 is lowest still enabled
// - Code 0 disables its source
`timescale 1ns/1ps
`include "ipl_defines.svh"

module ipl_prio_regs #(
  parameter int ADDR_W = 8
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic [ADDR_W-1:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [ADDR_W-1:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  output logic [2:0] ENC_LEVEL_O,
  output logic [2:0] PWM_LEVEL_O,
  output logic [2:0] CAN_LEVEL_O,
  output logic ENC_EN_O,
  output logic PWM_EN_O,
  output logic CAN_EN_O
);

  // Decode needs at least one index bit above the byte lanes
  if (ADDR_W < 3 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ipl_prio_regs: ADDR_W must lie in 3..32");
  end

  localparam logic [ADDR_W-1:0] PRIO_ADDR = ADDR_W'(`IPL_PRIO_OFF);

  // ==================================================
  // Write channel: address and data taken in either order
  logic aw_full_reg;
  logic w_full_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  ipl_pkg::ipl_wreq_t wreq_reg;

  wire aw_take = AWVALID_I && !aw_full_reg && !bvalid_reg;
  wire w_take = WVALID_I && !w_full_reg && !bvalid_reg;
  wire aw_hit = AWADDR_I[ADDR_W-1:`IPL_PRIO_IDX_LSB] ==
                PRIO_ADDR[ADDR_W-1:`IPL_PRIO_IDX_LSB];
  wire wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
  wire wr_hit = wr_fire && wreq_reg.hit;
  wire b_done = bvalid_reg && BREADY_I;

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `IPL_RESP_OKAY;
      wreq_reg <= '0;
    end else begin
      if (aw_take) begin
        aw_full_reg <= 1'b1;
        wreq_reg.hit <= aw_hit;
      end
      if (w_take) begin
        w_full_reg <= 1'b1;
        wreq_reg.data <= WDATA_I;
        wreq_reg.strb <= WSTRB_I;
      end
      if (wr_fire) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wreq_reg.hit ? `IPL_RESP_OKAY : `IPL_RESP_SLVERR;
      end else if (b_done) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Ready is a flop; each dropped while its own half, a whole request or the answer waits
  logic awready_reg;
  logic wready_reg;

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
    end else begin
      awready_reg <= !(aw_full_reg || aw_take || wr_fire || bvalid_reg) || b_done;
      wready_reg <= !(w_full_reg || w_take || wr_fire || bvalid_reg) || b_done;
    end
  end

  // ==================================================
  // Priority register
  ipl_pkg::ipl_levels_t lv_reg;
  ipl_pkg::ipl_levels_t lv_next;

  wire [15:0] lv_image = {5'h00, lv_reg.enc, 1'b0, lv_reg.pwm, 1'b0, lv_reg.can};
  wire [15:0] byte_mask = {{8{wreq_reg.strb[1]}}, {8{wreq_reg.strb[0]}}};
  wire [15:0] wr_merged = ((lv_image & ~byte_mask) | (wreq_reg.data[15:0] & byte_mask))
                          & `IPL_WR_MASK;

  // Only implemented bits are stored; the gaps stay zero
  assign lv_next.enc = wr_hit ? wr_merged[`IPL_ENC_LSB +: `IPL_FIELD_W]
                              : lv_reg.enc;
  assign lv_next.pwm = wr_hit ? wr_merged[`IPL_PWM_LSB +: `IPL_FIELD_W]
                              : lv_reg.pwm;
  assign lv_next.can = wr_hit ? wr_merged[`IPL_CAN_LSB +: `IPL_FIELD_W]
                              : lv_reg.can;

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      lv_reg <= '{enc: `IPL_ENC_RST, pwm: `IPL_PWM_RST, can: `IPL_CAN_RST};
    end else begin
      lv_reg <= lv_next;
    end
  end

  // ==================================================
  // Source enables, registered alongside the levels
  // Level code passes straight through: 7 highest, 1 lowest
  wire [2:0][2:0] lv_next_arr = {lv_next.enc, lv_next.pwm, lv_next.can};
  wire [2:0] en_next;
  logic [2:0] en_reg;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_en
      assign en_next[gi] = lv_next_arr[gi] != `IPL_LEVEL_OFF;
    end
  endgenerate

  // One flop vector, so each bit has a single writer
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      en_reg <= 3'h7;
    end else begin
      en_reg <= en_next;
    end
  end

  // ==================================================
  // Read channel: answer one cycle after the address is taken
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  wire ar_take = ARVALID_I && arready_reg;
  wire ar_hit = ARADDR_I[ADDR_W-1:`IPL_PRIO_IDX_LSB] ==
                PRIO_ADDR[ADDR_W-1:`IPL_PRIO_IDX_LSB];
  wire [31:0] rd_word = ar_hit ? {16'h0000, lv_image} : 32'h0000_0000;
  wire r_done = rvalid_reg && RREADY_I;

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `IPL_RESP_OKAY;
    end else begin
      if (ar_take) begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_word;
        rresp_reg <= ar_hit ? `IPL_RESP_OKAY : `IPL_RESP_SLVERR;
      end else if (r_done) begin
        arready_reg <= 1'b1;
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ==================================================
  // Outputs
  assign AWREADY_O = awready_reg;
  assign WREADY_O = wready_reg;
  assign BVALID_O = bvalid_reg;
  assign BRESP_O = bresp_reg;
  assign ARREADY_O = arready_reg;
  assign RVALID_O = rvalid_reg;
  assign RDATA_O = rdata_reg;
  assign RRESP_O = rresp_reg;
  assign ENC_LEVEL_O = lv_reg.enc;
  assign PWM_LEVEL_O = lv_reg.pwm;
  assign CAN_LEVEL_O = lv_reg.can;
  assign ENC_EN_O = en_reg[2];
  assign PWM_EN_O = en_reg[1];
  assign CAN_EN_O = en_reg[0];

  // ==================================================
  // Checks
  // Byte lanes decide which fields a write may touch
  sequence s_wr_low;
    wr_hit && wreq_reg.strb[0];
  endsequence

  sequence s_wr_high;
    wr_hit && wreq_reg.strb[1];
  endsequence

  sequence s_wr_miss;
    wr_fire && !wreq_reg.hit;
  endsequence

  // A waiting answer must stand still until the master takes it
  sequence s_b_wait;
    BVALID_O && !BREADY_I;
  endsequence

  sequence s_r_wait;
    RVALID_O && !RREADY_I;
  endsequence

  a_pwm_field_write: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    s_wr_low |=> PWM_LEVEL_O == $past(wreq_reg.data[6:4]))
    else $error("PWM level not taken from write data");

  a_can_field_write: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    s_wr_low |=> CAN_LEVEL_O == $past(wreq_reg.data[2:0]))
    else $error("CAN level not taken from write data");

  a_enc_field_write: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    s_wr_high |=> ENC_LEVEL_O == $past(wreq_reg.data[10:8]))
    else $error("Encoder level not taken from write data");

  a_top_level_on: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (PWM_LEVEL_O == `IPL_LEVEL_MAX) |-> PWM_EN_O)
    else $error("Level 7 source not enabled");

  a_low_level_on: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (CAN_LEVEL_O == `IPL_LEVEL_MIN) |-> CAN_EN_O)
    else $error("Level 1 source not enabled");

  a_zero_disables: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (ENC_LEVEL_O == `IPL_LEVEL_OFF) |-> !ENC_EN_O)
    else $error("Level 0 source still enabled");

  a_en_tracks_level: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    {ENC_EN_O, PWM_EN_O, CAN_EN_O} == {ENC_LEVEL_O != `IPL_LEVEL_OFF,
      PWM_LEVEL_O != `IPL_LEVEL_OFF, CAN_LEVEL_O != `IPL_LEVEL_OFF})
    else $error("Enable does not follow level");

  a_read_gaps_zero: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    RVALID_O |-> (RDATA_O[31:11] == 21'h0 && !RDATA_O[7] && !RDATA_O[3]))
    else $error("Unused read bits not zero");

  a_rd_image: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (ar_take && ar_hit) |=> RDATA_O[15:0] == $past(lv_image))
    else $error("Read data not the register image");

  a_miss_no_change: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    s_wr_miss |=> $stable(lv_reg))
    else $error("Unmapped write changed a level");

  a_miss_slverr: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    s_wr_miss |=> BVALID_O && BRESP_O == `IPL_RESP_SLVERR)
    else $error("Unmapped write not refused");

  a_write_answer: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    wr_hit |=> BVALID_O && BRESP_O == `IPL_RESP_OKAY)
    else $error("Write answer missing");

  a_write_once: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    wr_fire |=> !wr_fire)
    else $error("Write applied twice");

  a_b_holds: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    s_b_wait |=> BVALID_O && $stable(BRESP_O))
    else $error("Write answer dropped before taken");

  a_r_holds: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    s_r_wait |=> RVALID_O && $stable(RDATA_O) && $stable(RRESP_O))
    else $error("Read answer dropped before taken");

  a_busy_no_ready: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    BVALID_O |-> !AWREADY_O && !WREADY_O)
    else $error("Write ready while answer pending");

  a_aw_take_ready: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    aw_take |-> AWREADY_O)
    else $error("Write address taken without ready");

  a_w_take_ready: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    w_take |-> WREADY_O)
    else $error("Write data taken without ready");

  a_read_busy: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    RVALID_O |-> !ARREADY_O)
    else $error("Read ready while answer pending");

  a_read_answer: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (ARVALID_I && ARREADY_O) |=> RVALID_O && !ARREADY_O)
    else $error("Read answer not one cycle after address");

endmodule : ipl_prio_regs

// ==== verilog/ipl_defines.svh ====
`ifndef IPL_DEFINES_SVH
`define IPL_DEFINES_SVH

// ==================================================
// Register map
`define IPL_PRIO_OFF 8'h00
`define IPL_PRIO_IDX_LSB 2

// ==================================================
// Field positions inside the priority register
`define IPL_CAN_LSB 0
`define IPL_PWM_LSB 4
`define IPL_ENC_LSB 8
`define IPL_FIELD_W 3
`define IPL_WR_MASK 16'h0777

// ==================================================
// Reset values and level codes
`define IPL_ENC_RST 3'h4
`define IPL_PWM_RST 3'h4
`define IPL_CAN_RST 3'h4
`define IPL_LEVEL_OFF 3'h0
`define IPL_LEVEL_MIN 3'h1
`define IPL_LEVEL_MAX 3'h7

// ==================================================
// Bus answer codes
`define IPL_RESP_OKAY 2'h0
`define IPL_RESP_SLVERR 2'h2

`endif

// ==== verilog/ipl_pkg.sv ====
package ipl_pkg;

  typedef logic [2:0] ipl_level_t;

  // Priority levels of the three sources, one register image
  typedef struct packed {
    ipl_level_t enc;
    ipl_level_t pwm;
    ipl_level_t can;
  } ipl_levels_t;

  // Latched write request
  typedef struct packed {
    logic hit;
    logic [31:0] data;
    logic [3:0] strb;
  } ipl_wreq_t;

endpackage : ipl_pkg

// ==== bench/ipl_arb_model.sv ====
`timescale 1ns/1ps
// ==================================================
// Arbitration model: 0 none, 1 encoder, 2 pwm, 3 can
module ipl_arb_model (
  input wire logic [2:0] enc_level_i,
  input wire logic [2:0] pwm_level_i,
  input wire logic [2:0] can_level_i,
  input wire logic enc_en_i,
  input wire logic pwm_en_i,
  input wire logic can_en_i,
  output logic [1:0] winner_o
);
  logic [2:0] best;
  // Ties go to the earlier source; strict compare keeps code 0 out
  always_comb begin
    winner_o = 2'h0;
    best = 3'h0;
    if (enc_en_i && enc_level_i > best) begin
      winner_o = 2'h1;
      best = enc_level_i;
    end
    if (pwm_en_i && pwm_level_i > best) begin
      winner_o = 2'h2;
      best = pwm_level_i;
    end
    if (can_en_i && can_level_i > best) begin
      winner_o = 2'h3;
    end
  end
endmodule : ipl_arb_model

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic clk, rst_n, awv, wv, br, arv, rr;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd;
  logic [3:0] ws;
  logic awr, wrd, bv, arr, rv, ee, pe, ce;
  logic [1:0] bresp, rresp, win;
  logic [2:0] el, pl, cl;
  logic [11:0] av [5] = '{12'h170, 12'h143, 12'h100, 12'h000, 12'h007};
  logic [1:0] aw [5] = '{2'h2, 2'h2, 2'h1, 2'h0, 2'h3};
  int fail_count, checks_done;
  ipl_prio_regs ipl_prio_regs_inst (.SYS_CLK_I(clk), .RST_N_I(rst_n), .AWADDR_I(awa),
    .AWVALID_I(awv), .AWREADY_O(awr), .WDATA_I(wd), .WSTRB_I(ws), .WVALID_I(wv),
    .WREADY_O(wrd), .BRESP_O(bresp), .BVALID_O(bv), .BREADY_I(br), .ARADDR_I(ara),
    .ARVALID_I(arv), .ARREADY_O(arr), .RDATA_O(rd), .RRESP_O(rresp), .RVALID_O(rv),
    .RREADY_I(rr), .ENC_LEVEL_O(el), .PWM_LEVEL_O(pl), .CAN_LEVEL_O(cl),
    .ENC_EN_O(ee), .PWM_EN_O(pe), .CAN_EN_O(ce));
  ipl_arb_model ipl_arb_model_inst (.enc_level_i(el), .pwm_level_i(pl), .can_level_i(cl),
    .enc_en_i(ee), .pwm_en_i(pe), .can_en_i(ce), .winner_o(win));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ==================================================
  // Checks and bus tasks
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  task hang;
    fail_count++;
    $display("BAD %0t bus wait ran out", $time);
    tally_and_finish;
  endtask : hang
  // Ready sampled at the falling edge, so no race with the rising edge
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] er);
    logic ra, rw, b;
    logic [1:0] q;
    int n;
    awa <= a;
    wd <= d;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    b = 1'b0;
    n = 0;
    while (!b) begin
      @(negedge clk);
      ra = awr;
      rw = wrd;
      b = bv;
      q = bresp;
      @(posedge clk);
      if (ra) awv <= 1'b0;
      if (rw) wv <= 1'b0;
      n++;
      if (n > 50) hang;
    end
    br <= 1'b0;
    // Idle edge: the next call must not rewrite bready in this step
    @(posedge clk);
    chk({30'h0, q}, {30'h0, er});
  endtask : wr
  task rdk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ra, r;
    logic [31:0] d;
    logic [1:0] q;
    int n;
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    r = 1'b0;
    n = 0;
    while (!r) begin
      @(negedge clk);
      ra = arr;
      r = rv;
      d = rd;
      q = rresp;
      @(posedge clk);
      if (ra) arv <= 1'b0;
      n++;
      if (n > 50) hang;
    end
    rr <= 1'b0;
    @(posedge clk);
    chk(d, e);
    chk({30'h0, q}, {30'h0, er});
  endtask : rdk
  // ==================================================
  // Tests
  initial begin
    {awv, wv, br, arv, rr} = 5'h00;
    awa = 8'h00;
    ara = 8'h00;
    wd = 32'h0;
    ws = 4'h0;
    rst_n = 1'b0;
    fail_count = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdk(8'h00, 32'h444, 2'h0);
    chk({ee, pe, ce, el, pl, cl}, {3'h7, 9'h124});
    wr(8'h00, 32'hFFFFFFFF, 4'hF, 2'h0);
    rdk(8'h00, 32'h777, 2'h0);
    $display("test reset and field map done");
    for (int c = 0; c < 8; c++) begin
      wr(8'h00, {21'h0, c[2:0], 1'b0, c[2:0], 1'b0, c[2:0]}, 4'hF, 2'h0);
      chk({el, pl, cl}, {3{c[2:0]}});
      chk({ee, pe, ce}, {3{c != 0}});
    end
    $display("test level codes done");
    for (int i = 0; i < 5; i++) begin
      wr(8'h00, {20'h0, av[i]}, 4'hF, 2'h0);
      chk({30'h0, win}, {30'h0, aw[i]});
    end
    $display("test arbitration done");
    wr(8'h00, 32'h00000700, 4'h2, 2'h0);
    rdk(8'h00, 32'h707, 2'h0);
    wr(8'h00, 32'h00000000, 4'h1, 2'h0);
    rdk(8'h00, 32'h700, 2'h0);
    wr(8'h04, 32'h0, 4'hF, 2'h2);
    rdk(8'h04, 32'h0, 2'h2);
    rdk(8'h00, 32'h700, 2'h0);
    $display("test strobes and unmapped done");
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({ee, pe, ce, el, pl, cl}, {3'h7, 9'h124});
    rdk(8'h00, 32'h444, 2'h0);
    $display("test mid-run reset done");
    tally_and_finish;
  end
endmodule : tb_top
